//--- bench/drive_outer_loop_supervisor_tb.sv
// Purpose: Self-checking bench of the drive supervisor
// Assumes: Short speed tick of 8 cycles
// Notes:   Outer output checked after one outer tick, or after two in the lead/lag case
`timescale 1ns/1ps
module drive_outer_loop_supervisor_tb;
  import drive_sup_pkg::*;
  localparam int unsigned TICK = 8;
  logic core_clk, rst = 1'b1, err, pready, pslverr, speedTick, outerTick;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, enReq = 1'b0;
  logic driveRunning = 1'b0, netCtrlEnBit, meterEnIn, openLoop, outerActive;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  board_t boardSel = BOARD_NONE, board;
  vec_mode_t vecMode = ENCODER_VEC;
  meas_t meas;
  comp_t comp = '{16'h0010, 16'h0020, 16'h0030};
  logic signed [15:0] speedRefIn = 16'h0100, speedPiTorque = 16'h0100;
  logic signed [15:0] torqueLoopOut = 16'h0555, vhzVoltage = 16'h0444;
  logic signed [15:0] speedFbk, trimmedSpeedRef, torqueRef, gateCmd;
  board_t bl[5] = '{BOARD_NONE, BOARD_NONE, BOARD_METER, BOARD_METER,
                    BOARD_NET};
  logic [3:0] sl[5] = '{4'h0, 4'h3, 4'h0, 4'h8, 4'h0};
  logic [15:0] el[5] = '{16'h0800, 16'h0300, 16'h0400, 16'h0800, 16'h0600};
  int num_errors = 0;
  int checked = 0;
  drive_outer_loop_supervisor #(.SPEED_TICK(TICK)) dut (.*);
  option_board_model board_model (.*);
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = !core_clk;
  end
  task automatic wrap_up();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One APB transfer, held until ready
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      num_errors++;
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb
  // Bounded wait for outer enable (0) or outer tick (1)
  task automatic wait_hi(input bit which);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while ((which ? outerTick : outerActive) !== 1'b1 && n < 200);
    if (n >= 200) begin
      num_errors++;
      wrap_up();
    end
  endtask : wait_hi
  // Main sequence
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl", CTRL_RESET, rd);
    chk("openLoop", 32'h1, 32'(openLoop));
    chk("fbkVhz", 32'h0, 32'(speedFbk));
    chk("gateVhz", 32'(vhzVoltage), 32'(gateCmd));
    apb(1'b0, 8'h08, 32'h0);
    chk("slverr", 32'h1, 32'(err));
    chk("badRead", 32'h0, rd);
    for (int k = 1; k <= 8; k++) apb(1'b1, 8'(12 + 4 * k), 32'(k * 256));
    apb(1'b1, NETREF_OFS, 32'h0000_0600);
    apb(1'b0, PRESET_OFS + 8'h1C, 32'h0);
    chk("preset8", 32'h0000_0800, rd);
    apb(1'b1, CTRL_OFS, 32'h0000_0001);
    repeat (2) @(posedge core_clk);
    chk("vector", 32'h0, 32'(openLoop));
    chk("fbkEnc", 32'h0222, 32'(speedFbk));
    chk("torque", 32'h0160, 32'(torqueRef));
    chk("gateVec", 32'(torqueLoopOut), 32'(gateCmd));
    vecMode <= ESTIMATED_VEC;
    repeat (2) @(posedge core_clk);
    chk("fbkEst", 32'h0333, 32'(speedFbk));
    // Reference choice per board and select value
    for (int i = 0; i < 5; i++) begin
      boardSel <= bl[i];
      enReq <= 1'b1;
      apb(1'b1, CTRL_OFS, 32'({sl[i], 4'h1}));
      // Start running just after a tick so only one update is seen
      wait_hi(1'b1);
      driveRunning <= 1'b1;
      wait_hi(1'b0);
      wait_hi(1'b1);
      repeat (2) @(posedge core_clk);
      apb(1'b0, OUTFB_OFS, 32'h0);
      chk("outer", 32'(el[i][15:3]), rd);
      chk("trim", 32'(16'(speedRefIn + el[i][15:3])),
          32'(trimmedSpeedRef));
      if (bl[i] == BOARD_NET) enReq <= 1'b0;
      else driveRunning <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk("active", 32'h0, 32'(outerActive));
      driveRunning <= 1'b0;
      apb(1'b0, OUTFB_OFS, 32'h0);
      chk("held", 32'h0, rd);
    end
    // Meter input enable, speed PI feedback, lead/lag filter
    boardSel <= BOARD_METER;
    enReq <= 1'b0;
    apb(1'b1, CTRL_OFS, 32'h0000_0137);
    driveRunning <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk("meterOff", 32'h0, 32'(outerActive));
    wait_hi(1'b1);
    enReq <= 1'b1;
    wait_hi(1'b0);
    wait_hi(1'b1);
    wait_hi(1'b1);
    repeat (2) @(posedge core_clk);
    apb(1'b0, OUTFB_OFS, 32'h0);
    chk("fbLeadLag", 32'h0000_008C, rd);
    enReq <= 1'b0;
    driveRunning <= 1'b0;
    apb(1'b1, CTRL_OFS, 32'h0);
    repeat (2) @(posedge core_clk);
    chk("backVhz", 32'h1, 32'(openLoop));
    wrap_up();
  end
endmodule : drive_outer_loop_supervisor_tb

//--- bench/drive_sup_props.sv
// Purpose: Port checker for the drive supervisor
// Assumes: APB answers in the access cycle
// Notes:   Counters measure tick spacing
`timescale 1ns/1ps
module drive_sup_props #(
  parameter int unsigned SPEED_TICK = 8
) (
  // Clock and reset
  input wire logic                  core_clk,
  input wire logic                  rst,
  // APB
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  // Board and drive state
  input wire drive_sup_pkg::board_t board,
  input wire logic                  netCtrlEnBit,
  input wire logic                  driveRunning,
  // Pacing and loop state
  input wire logic                  speedTick,
  input wire logic                  outerTick,
  input wire logic                  openLoop,
  input wire logic                  outerActive
);
  import drive_sup_pkg::*;
  localparam int unsigned GAP = SPEED_TICK - 1;
  int unsigned spCnt_q;
  int unsigned tkCnt_q;
  logic        spOk_q;
  logic        tkOk_q;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Cycles since last speed tick, speed ticks since last outer tick
  always_ff @(posedge core_clk) begin
    if (rst || openLoop) begin
      spCnt_q <= 0;
      tkCnt_q <= 0;
      spOk_q  <= 1'b0;
      tkOk_q  <= 1'b0;
    end else begin
      spCnt_q <= speedTick ? 0 : spCnt_q + 1;
      spOk_q  <= spOk_q | speedTick;
      tkOk_q  <= tkOk_q | outerTick;
      if (outerTick) tkCnt_q <= 0;
      else if (speedTick) tkCnt_q <= tkCnt_q + 1;
    end
  end
  property p_apb_answer; psel && !penable |=> pready; endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("no ready");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready long");
  property p_err_zero; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err_zero: assert property (p_err_zero) else $error("bad error read");
  property p_speed_gap; speedTick && spOk_q |-> spCnt_q == GAP; endproperty
  a_speed_gap: assert property (p_speed_gap) else $error("speed gap");
  property p_outer_four; outerTick && tkOk_q |-> tkCnt_q == 3; endproperty
  a_outer_four: assert property (p_outer_four) else $error("outer");
  property p_outer_sync; outerTick |-> speedTick; endproperty
  a_outer_sync: assert property (p_outer_sync) else $error("unsync");
  property p_vhz_quiet; openLoop [*3] |-> !speedTick; endproperty
  a_vhz_quiet: assert property (p_vhz_quiet) else $error("vhz tick");
  property p_run_gate; !driveRunning |=> !outerActive; endproperty
  a_run_gate: assert property (p_run_gate) else $error("stopped");
  property p_net_en; board == BOARD_NET && !netCtrlEnBit |=> !outerActive;
  endproperty
  a_net_en: assert property (p_net_en) else $error("net enable");
  property p_none_en;
    (board == BOARD_NONE && driveRunning && !openLoop) [*2] |=> outerActive;
  endproperty
  a_none_en: assert property (p_none_en) else $error("no enable");
  c_tick: cover property (outerTick && outerActive);
  c_err: cover property (pslverr);
  c_net: cover property (board == BOARD_NET && outerActive);
endmodule : drive_sup_props
bind drive_outer_loop_supervisor drive_sup_props #(
  .SPEED_TICK(SPEED_TICK)) chk (.*);

//--- bench/option_board_model.sv
// Purpose: Option board stand-in feeding presence, enables, measurements
// Assumes: Board type fixed by the bench
// Notes:   Enable lines of absent boards toggle each cycle
`timescale 1ns/1ps
module option_board_model (
  // Clock
  input  wire logic                  core_clk,
  // Bench controls
  input  wire drive_sup_pkg::board_t boardSel,
  input  wire logic                  enReq,
  // Board outputs
  output drive_sup_pkg::board_t      board,
  output logic                       netCtrlEnBit,
  output logic                       meterEnIn,
  output drive_sup_pkg::meas_t       meas
);
  import drive_sup_pkg::*;
  logic flip_q = 1'b0;
  // Undriven lines must not hold a stale level
  always_ff @(posedge core_clk) flip_q <= !flip_q;
  // Only the fitted board drives its enable
  assign netCtrlEnBit = (boardSel == BOARD_NET) ? enReq : flip_q;
  assign meterEnIn = (boardSel == BOARD_METER) ? enReq : flip_q;
  assign board = boardSel;
  assign meas = '{16'h0000, 16'h0400, 16'h0111, 16'h0222, 16'h0333};
endmodule : option_board_model

//--- design/drive_outer_loop_supervisor.sv
// Purpose: Supervisor of regulation mode, loop pacing and outer trim loop
// Assumes: Single core clock, APB register access, inputs synchronous
// Notes:   Numeric PI and modulator internals live outside this block
//
// Overview of operation
// R1: Regulation type bit selects volts-per-hertz or vector regulation.
// R2: Volts-per-hertz runs open loop; voltage follows frequency and motor data.
// R3: Vector regulation issues a speed loop update every 5 ms.
// R4: The outer trim loop updates every 20 ms.
// R5: Encoder mode uses encoder speed; estimated mode uses estimated speed.
// R6: Outer loop output only trims the speed loop reference.
// R7: Network board present: trim reference from selected network register.
// R8: Meter board: select 0 gives meter analog, 1..8 give presets.
// R9: No board: select 0 gives preset eight, 1..8 give presets.
// R10: Outer feedback is terminal analog by default or speed PI output.
// R11: Feedback passes a lead/lag, lag/lead or null filter stage.
// R12: Network board: outer enable follows a control word bit.
// R13: Meter board: enable follows meter input or speed loop enable.
// R14: No board: enable follows running controllers, off when stopped.
// R15: Outer loop operates only while running and enabled, else reset.
// R16: Speed loop adds inertia, losses and compounding terms to torque.
// R17: Vector torque loop output drives the PWM gate commands.
// R18: Both loop ticks come from one counter; outer is every fourth.
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ps
module drive_outer_loop_supervisor #(
  parameter int unsigned SPEED_TICK = drive_sup_pkg::SPEED_CYCLES,
  parameter int unsigned W          = 16
) (
  // Clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Option board and drive state
  input  wire drive_sup_pkg::board_t      board,
  input  wire drive_sup_pkg::vec_mode_t   vecMode,
  input  wire logic                       netCtrlEnBit,
  input  wire logic                       meterEnIn,
  input  wire logic                       driveRunning,
  // Measurements and references
  input  wire drive_sup_pkg::meas_t       meas,
  input  wire drive_sup_pkg::comp_t       comp,
  input  wire logic signed [15:0]         speedRefIn,
  input  wire logic signed [15:0]         speedPiTorque,
  input  wire logic signed [15:0]         torqueLoopOut,
  input  wire logic signed [15:0]         vhzVoltage,
  // Loop pacing and results
  output logic                            speedTick,
  output logic                            outerTick,
  output logic                            openLoop,
  output logic                            outerActive,
  output logic signed [15:0]              speedFbk,
  output logic signed [15:0]              trimmedSpeedRef,
  output logic signed [15:0]              torqueRef,
  output logic signed [15:0]              gateCmd
);
  import drive_sup_pkg::*;

  initial begin
    if (SPEED_TICK < 2) $error("SPEED_TICK too small");
    if (W != 16) $error("W must be 16");
  end

  // Register state
  ctrl_t              ctrl_q;
  logic signed [15:0] preset_q [8];
  logic signed [15:0] netRef_q;
  logic [31:0]        tickCnt_q;
  logic [1:0]         subCnt_q;
  logic signed [15:0] outer_q;

  // Decodes
  logic        wrEn;
  logic        rdEn;
  logic        presetHit;
  logic [2:0]  presetIdx;
  logic        addrOk;
  logic        isVector;
  logic        tickWrap;
  logic        outerEn;
  logic        outerRun;
  logic signed [15:0] outerRef;
  logic signed [15:0] outerFbRaw;
  logic signed [15:0] outerFbFilt;
  logic signed [15:0] outerErr;
  logic [3:0]  sel;
  logic [31:0] rdMux;

  // Preset lookup: code 0 maps to preset eight, 1..8 map directly
  function automatic logic signed [15:0] pickPreset(
    input logic [3:0] s,
    input logic signed [15:0] p [8]);
    logic [2:0] i;
    i = (s == 4'h0 || s > TRIM_SEL_MAX) ? 3'h7 : 3'(s - 4'h1);
    return p[i];
  endfunction : pickPreset

  // APB decode
  assign wrEn      = psel && penable && pwrite;
  assign rdEn      = psel && penable && !pwrite;
  assign presetHit = paddr >= PRESET_OFS && paddr < NETREF_OFS;
  assign presetIdx = 3'((paddr - PRESET_OFS) >> 2);
  assign addrOk    = (paddr[1:0] == 2'b00) &&
                     (paddr == CTRL_OFS || paddr == STATUS_OFS ||
                      presetHit || paddr == NETREF_OFS ||
                      paddr == OUTFB_OFS);

  // Read data selection
  assign rdMux =
    (paddr == CTRL_OFS)   ? 32'(ctrl_q) :
    (paddr == STATUS_OFS) ? {26'h000_0000, outerActive, openLoop,
                             board, vecMode, isVector} :
    presetHit             ? {16'h0000, preset_q[presetIdx]} :
    (paddr == NETREF_OFS) ? {16'h0000, netRef_q} :
    (paddr == OUTFB_OFS)  ? {16'h0000, outer_q} : 32'h0000_0000;

  // Control register and reference writes
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_q   <= ctrl_t'(CTRL_RESET[8:0]);
      netRef_q <= WORD_ZERO;
    end else if (wrEn && paddr == CTRL_OFS) begin
      ctrl_q   <= ctrl_t'(pwdata[8:0]);
    end else if (wrEn && paddr == NETREF_OFS) begin
      netRef_q <= pwdata[15:0];
    end
  end

  // Preset speed storage, one word each
  for (genvar g = 0; g < 8; g++) begin : gPreset
    always_ff @(posedge core_clk) begin
      if (rst) begin
        preset_q[g] <= WORD_ZERO;
      end else if (wrEn && presetHit && presetIdx == 3'(g)) begin
        preset_q[g] <= pwdata[15:0];
      end
    end
  end

  // APB answer: zero wait states, error on unmapped address
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addrOk;
      prdata  <= (psel && !penable && !pwrite) ? rdMux : 32'h0000_0000;
    end
  end

  // Mode decode
  assign isVector = ctrl_q.regType == VECTOR_CODE; // R1

  // Common pacing counter for both loops
  assign tickWrap = tickCnt_q == SPEED_TICK - 1; // R18
  always_ff @(posedge core_clk) begin
    if (rst || !isVector) begin
      tickCnt_q <= 32'h0000_0000;
      subCnt_q  <= 2'h0;
    end else if (tickWrap) begin
      tickCnt_q <= 32'h0000_0000; // R3
      subCnt_q  <= subCnt_q + 2'h1; // R18
    end else begin
      tickCnt_q <= tickCnt_q + 32'h0000_0001;
    end
  end

  // Tick strobes, outer every OUTER_RATIO speed ticks
  always_ff @(posedge core_clk) begin
    if (rst) begin
      speedTick <= 1'b0;
      outerTick <= 1'b0;
    end else begin
      speedTick <= isVector && tickWrap; // R3
      outerTick <= isVector && tickWrap &&
                   subCnt_q == 2'(OUTER_RATIO - 1); // R4 R18
    end
  end

  // Outer loop reference by option board
  assign sel = ctrl_q.trimSel;
  assign outerRef =
    (board == BOARD_NET) ? netRef_q : // R7
    (board == BOARD_METER && sel == 4'h0) ? meas.meterAnalog : // R8
    pickPreset(sel, preset_q); // R8 R9

  // Outer loop enable by option board
  assign outerEn =
    (board == BOARD_NET)   ? netCtrlEnBit : // R12
    (board == BOARD_METER) ? (ctrl_q.meterEnSel ? meterEnIn
                                                : driveRunning) : // R13
    driveRunning; // R14
  assign outerRun = isVector && driveRunning && outerEn; // R15

  // Feedback source
  assign outerFbRaw = ctrl_q.fbSpeedPi ? meas.speedPiOut
                                       : meas.termAnalog; // R10

  lead_lag_filter #(
    .W     (W),
    .SHIFT (2)
  ) uFilt (
    .core_clk (core_clk),
    .rst      (rst),
    .hold     (!outerRun),
    .update   (outerTick),
    .mode     (ctrl_q.filtMode), // R11
    .din      (outerFbRaw),
    .dout     (outerFbFilt)
  );

  assign outerErr = 16'(outerRef - outerFbFilt);

  // Outer loop state, held in reset when not running or disabled
  always_ff @(posedge core_clk) begin
    if (rst || !outerRun) begin
      outer_q <= WORD_ZERO; // R15
    end else if (outerTick) begin
      outer_q <= 16'(outer_q + (outerErr >>> 3)); // R4
    end
  end

  // Loop outputs
  always_ff @(posedge core_clk) begin
    if (rst) begin
      openLoop        <= 1'b1;
      outerActive     <= 1'b0;
      speedFbk        <= WORD_ZERO;
      trimmedSpeedRef <= WORD_ZERO;
      torqueRef       <= WORD_ZERO;
      gateCmd         <= WORD_ZERO;
    end else begin
      openLoop    <= !isVector; // R2
      outerActive <= outerRun;
      speedFbk    <= !isVector ? WORD_ZERO : // R2
                     (vecMode == ENCODER_VEC) ? meas.encSpeed
                                              : meas.estSpeed; // R5
      trimmedSpeedRef <= 16'(speedRefIn + outer_q); // R6
      torqueRef <= 16'(speedPiTorque + comp.inertia + comp.losses
                       + comp.compound); // R16
      gateCmd   <= isVector ? torqueLoopOut : vhzVoltage; // R17 R2
    end
  end
endmodule : drive_outer_loop_supervisor

//--- design/drive_sup_pkg.sv
// Purpose: Shared constants, types and register map of the drive supervisor
// Assumes: 200 MHz core clock, APB slave with 32-bit data
// Notes:   Loop periods are derived from one base tick
package drive_sup_pkg;

  // Clock and loop timing
  localparam int unsigned CLK_MHZ         = 200;
  localparam int unsigned SPEED_PERIOD_MS = 5;
  localparam int unsigned OUTER_PERIOD_MS = 20;
  localparam int unsigned SPEED_CYCLES    = SPEED_PERIOD_MS * 1000 * CLK_MHZ;
  localparam int unsigned OUTER_RATIO     = OUTER_PERIOD_MS / SPEED_PERIOD_MS;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] PRESET_OFS = 8'h10; // Presets 1..8 at 0x10..0x2C
  localparam logic [7:0] NETREF_OFS = 8'h30;
  localparam logic [7:0] OUTFB_OFS  = 8'h34;

  // Control field positions
  localparam int unsigned REG_TYPE_BIT = 0;
  localparam int unsigned FB_SEL_BIT   = 1;
  localparam int unsigned LEAD_LSB     = 2;
  localparam int unsigned TRIM_SEL_LSB = 4;
  localparam int unsigned RMI_EN_BIT   = 8;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [15:0] WORD_ZERO  = 16'h0000;
  localparam logic [3:0]  TRIM_SEL_MAX = 4'h8;

  // Regulation type codes
  typedef enum logic {VOLTS_HZ = 1'b0, VECTOR_CODE = 1'b1} reg_type_t;
  // Speed feedback flavour within vector regulation
  typedef enum logic {ENCODER_VEC = 1'b0, ESTIMATED_VEC = 1'b1} vec_mode_t;
  // Option board presence
  typedef enum logic [1:0] {
    BOARD_NONE = 2'h0, BOARD_NET = 2'h1, BOARD_METER = 2'h2
  } board_t;
  // Outer feedback filter modes
  typedef enum logic [1:0] {
    FILT_NULL = 2'h0, FILT_LEAD_LAG = 2'h1, FILT_LAG_LEAD = 2'h2
  } filt_t;

  // Control configuration carried as one struct
  typedef struct packed {
    logic        meterEnSel;   // 1: meter digital input, 0: speed loop enable
    logic [3:0]  trimSel;
    filt_t       filtMode;
    logic        fbSpeedPi;    // 1: speed PI output, 0: terminal analog
    reg_type_t   regType;
  } ctrl_t;

  // Analog and speed quantities from the regulator
  typedef struct packed {
    logic signed [15:0] termAnalog;
    logic signed [15:0] meterAnalog;
    logic signed [15:0] speedPiOut;
    logic signed [15:0] encSpeed;
    logic signed [15:0] estSpeed;
  } meas_t;

  // Compensation terms added to the torque reference
  typedef struct packed {
    logic signed [15:0] inertia;
    logic signed [15:0] losses;
    logic signed [15:0] compound;
  } comp_t;

endpackage : drive_sup_pkg

//--- design/lead_lag_filter.sv
// Purpose: First-order lead/lag stage for the outer loop feedback
// Assumes: Update strobe once per outer period
// Notes:   Null mode passes input unchanged; state cleared by hold
`timescale 1ns/1ps
module lead_lag_filter #(
  parameter int unsigned W     = 16,
  parameter int unsigned SHIFT = 2
) (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst,
  // Control
  input  wire logic                hold,
  input  wire logic                update,
  input  wire drive_sup_pkg::filt_t mode,
  // Data
  input  wire logic signed [W-1:0] din,
  output logic signed [W-1:0]      dout
);
  import drive_sup_pkg::*;

  initial begin
    if (W < 4 || SHIFT >= W) $error("lead_lag_filter: bad width");
  end

  logic signed [W-1:0] avg_q;
  logic signed [W-1:0] avg_d;
  logic signed [W-1:0] diff;
  logic signed [W-1:0] yOut;

  // Low-pass state and lead/lag combination
  assign diff  = din - avg_q;
  assign avg_d = avg_q + (diff >>> SHIFT);
  assign yOut  = (mode == FILT_LEAD_LAG) ? W'(din + (diff >>> 1)) :
                 (mode == FILT_LAG_LEAD) ? avg_d : din;

  // State update on each outer tick, cleared while held
  always_ff @(posedge core_clk) begin
    if (rst || hold) begin
      avg_q <= '0;
      dout  <= '0;
    end else if (update) begin
      avg_q <= avg_d;
      dout  <= yOut;
    end
  end
endmodule : lead_lag_filter
